// ===== hsl_cfg.svh
`ifndef HSL_CFG_SVH
`define HSL_CFG_SVH
// register byte offsets (full address decode on adr_i[15:0])
`define HSL_STAT_A_OFS 16'h7008
`define HSL_STAT_B_OFS 16'h8008
`define HSL_MASK_A_OFS 16'h700C
`define HSL_MASK_B_OFS 16'h800C
`define HSL_CTRL_OFS 16'h9000
// field positions inside the status word
`define HSL_RB_LO 0
`define HSL_RB_HI 3
`define HSL_TX_FRAME_DONE_FLAG_BIT 4
`define HSL_TX_FIFO_SPACE_FLAG_BIT 5
`define HSL_CTS_BIT 6
`define HSL_SCTS_BIT 7
`define HSL_TXU_BIT 8
`define HSL_RX_FIFO_DATA_FLAG_BIT 9
`define HSL_RSV_BIT 10
// control register fields, one nibble per channel
`define HSL_CTL_FOUR 0
`define HSL_CTL_TXDMA 1
`define HSL_CTL_RXDMA 2
`define HSL_CTL_STRIDE 4
// writable sticky bits: 4, 7, 8
`define HSL_STICKY_MASK 11'h190
`define HSL_STAT_RST 32'h0000_0000
`define HSL_MASK_RST 11'h000
`define HSL_CTRL_RST 8'h00
`endif

// ===== hsl_pkg.sv
package hsl_pkg;
   typedef struct packed {
      logic [1:0] cts_sync1;
      logic [1:0] cts_sync2;
      logic [1:0] cts_prev;
      logic [1:0][3:0] rb;
      logic [1:0][2:0] sticky;
      logic [1:0][10:0] mask;
      logic [7:0] ctrl;
      logic ack;
      logic [31:0] dat;
   } hsl_state_t;
endpackage

// ===== hsl_status.sv
`timescale 1ns/1ps
// Functional notes
// - Each channel has one status word, A at 0x7008 and B at 0x8008, reset to zero.
// - Reading a status word changes no bit.
// - Level bits 5 and 9 follow their conditions with no storage; bit 6 passes through two sync flops.
// - Bits 4, 7 and 8 are sticky and clear only by writing one.
// - Bits 3:0 hold leftover valid bytes minus one of a finished receive frame.
// - Bit 4 sets when transmit FIFO is empty and an abort or closing flag went out.
// - In single-word mode bit 5 is one while the first transmit FIFO word is empty.
// - In four-word mode bit 5 is one only while the first four words are empty.
// - While transmit DMA runs, bit 5 reads zero.
// - Bit 6 is the inverted clear-to-send pin level and raises no interrupt.
// - Bit 7 sets on any clear-to-send edge until written with one.
// - A mid-frame underrun sets bit 8, cleared by writing one.
// - In single-word mode bit 9 is one when the last receive FIFO word holds data.
// - In four-word mode bit 9 is one when the last four receive words hold data.
// - In four-word mode, two words with the frame-last marker also count as receive data available.
// - While receive DMA runs, bit 9 reads zero.
`include "hsl_cfg.svh"
module hsl_status (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [15:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o,
   input wire logic [1:0] clear_to_send_n_i,
   input wire logic [1:0] tx_fifo_first_empty_i,
   input wire logic [1:0] tx_fifo_four_empty_i,
   input wire logic [1:0] tx_done_event_i,
   input wire logic [1:0] tx_underrun_event_i,
   input wire logic [1:0] rx_fifo_last_valid_i,
   input wire logic [1:0] rx_fifo_four_valid_i,
   input wire logic [1:0] rx_fifo_two_last_i,
   input wire logic [1:0] rx_frame_end_i,
   input wire logic [1:0][3:0] rx_leftover_byte_count_i
);

   hsl_pkg::hsl_state_t st;
   hsl_pkg::hsl_state_t next_st;
   // one word per channel, each filled by its own process
   logic [10:0] stat [2];
   logic [1:0] cts_edge;

   function automatic logic [2:0] reg_sel(input logic [15:0] a);
      reg_sel = 3'h0;
      case (a)
         `HSL_STAT_A_OFS: reg_sel = 3'h1;
         `HSL_STAT_B_OFS: reg_sel = 3'h2;
         `HSL_MASK_A_OFS: reg_sel = 3'h3;
         `HSL_MASK_B_OFS: reg_sel = 3'h4;
         `HSL_CTRL_OFS: reg_sel = 3'h5;
         default: reg_sel = 3'h0;
      endcase
   endfunction

   logic [2:0] sel_reg;
   logic req;
   assign sel_reg = reg_sel(adr_i);
   assign req = cyc_i && stb_i && !st.ack;

   generate
      for (genvar c = 0; c < 2; c++) begin : g_ch
         logic four;
         logic txdma;
         logic rxdma;
         logic tx_fa;
         logic rx_fa;
         assign four = st.ctrl[c*`HSL_CTL_STRIDE+`HSL_CTL_FOUR];
         assign txdma = st.ctrl[c*`HSL_CTL_STRIDE+`HSL_CTL_TXDMA];
         assign rxdma = st.ctrl[c*`HSL_CTL_STRIDE+`HSL_CTL_RXDMA];
         // dma owns the fifo, so software polling is suppressed
         assign tx_fa = !txdma && (four ? tx_fifo_four_empty_i[c]
                                        : tx_fifo_first_empty_i[c]);
         assign rx_fa = !rxdma && (four ? (rx_fifo_four_valid_i[c]
                                           || rx_fifo_two_last_i[c])
                                        : rx_fifo_last_valid_i[c]);
         assign cts_edge[c] = st.cts_sync2[c] ^ st.cts_prev[c];
         always_comb begin
            stat[c] = 11'h000;
            stat[c][`HSL_RB_HI:`HSL_RB_LO] = st.rb[c];
            stat[c][`HSL_TX_FRAME_DONE_FLAG_BIT] = st.sticky[c][0];
            stat[c][`HSL_TX_FIFO_SPACE_FLAG_BIT] = tx_fa;
            stat[c][`HSL_CTS_BIT] = !st.cts_sync2[c];
            stat[c][`HSL_SCTS_BIT] = st.sticky[c][1];
            stat[c][`HSL_TXU_BIT] = st.sticky[c][2];
            stat[c][`HSL_RX_FIFO_DATA_FLAG_BIT] = rx_fa;
            stat[c][`HSL_RSV_BIT] = 1'b0;
         end
      end
   endgenerate

   always_comb begin
      logic [1:0] clr_hit;
      logic [2:0] clr_bits;
      logic [2:0] set_bits;
      clr_hit = 2'b00;
      clr_bits = 3'h0;
      set_bits = 3'h0;
      next_st = st;
      next_st.cts_sync1 = clear_to_send_n_i;
      next_st.cts_sync2 = st.cts_sync1;
      next_st.cts_prev = st.cts_sync2;
      next_st.ack = req;
      // byte enables are applied per bit below
      if (req && we_i && sel_reg == 3'h1) begin
         clr_hit[0] = 1'b1;
      end
      if (req && we_i && sel_reg == 3'h2) begin
         clr_hit[1] = 1'b1;
      end
      for (int c = 0; c < 2; c++) begin
         if (rx_frame_end_i[c]) begin
            next_st.rb[c] = rx_leftover_byte_count_i[c];
         end
         // bits 4, 7 live in byte 0; bit 8 in byte 1
         clr_bits[0] = clr_hit[c] && sel_i[0]
                       && dat_i[`HSL_TX_FRAME_DONE_FLAG_BIT];
         clr_bits[1] = clr_hit[c] && sel_i[0]
                       && dat_i[`HSL_SCTS_BIT];
         clr_bits[2] = clr_hit[c] && sel_i[1] && dat_i[`HSL_TXU_BIT];
         set_bits[0] = tx_done_event_i[c];
         set_bits[1] = cts_edge[c];
         set_bits[2] = tx_underrun_event_i[c];
         // a set in the clearing cycle wins
         next_st.sticky[c] = (st.sticky[c] & ~clr_bits) | set_bits;
      end
      if (req && we_i) begin
         case (sel_reg)
            3'h3: begin
               if (sel_i[0]) next_st.mask[0][7:0] = dat_i[7:0];
               if (sel_i[1]) next_st.mask[0][10:8] = dat_i[10:8];
            end
            3'h4: begin
               if (sel_i[0]) next_st.mask[1][7:0] = dat_i[7:0];
               if (sel_i[1]) next_st.mask[1][10:8] = dat_i[10:8];
            end
            3'h5: begin
               if (sel_i[0]) next_st.ctrl = dat_i[7:0];
            end
            default: begin
            end
         endcase
      end
      // reads only capture, never clear
      next_st.dat = 32'h0000_0000;
      if (req && !we_i) begin
         case (sel_reg)
            3'h1: next_st.dat = {21'h00_0000, stat[0]};
            3'h2: next_st.dat = {21'h00_0000, stat[1]};
            3'h3: next_st.dat = {21'h00_0000, st.mask[0]};
            3'h4: next_st.dat = {21'h00_0000, st.mask[1]};
            3'h5: next_st.dat = {24'h00_0000, st.ctrl};
            default: next_st.dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st.cts_sync1 <= 2'b11;
         st.cts_sync2 <= 2'b11;
         st.cts_prev <= 2'b11;
         st.rb <= '0;
         st.sticky <= '0;
         st.mask <= {`HSL_MASK_RST, `HSL_MASK_RST};
         st.ctrl <= `HSL_CTRL_RST;
         st.ack <= 1'b0;
         st.dat <= `HSL_STAT_RST;
      end else begin
         st <= next_st;
      end
   end

   // level bits 5 and 9 may interrupt; bit 6 is excluded
   logic [10:0] irq_src0;
   logic [10:0] irq_src1;
   assign irq_src0 = stat[0] & st.mask[0] & 11'h3B0;
   assign irq_src1 = stat[1] & st.mask[1] & 11'h3B0;
   assign irq_o = |irq_src0 || |irq_src1;
   assign ack_o = st.ack;
   assign dat_o = st.dat;

endmodule // hsl_status

// ===== hsl_modem.sv
`timescale 1ns/1ps
module hsl_modem (
   input wire logic clk_i,
   input wire logic [1:0] flip_i,
   output logic [1:0] clear_to_send_n_o
);
   // released modem line rests high, so reset sees no false edge
   initial clear_to_send_n_o = 2'h3;
   always @(posedge clk_i) begin
      clear_to_send_n_o <= clear_to_send_n_o ^ flip_i;
   end
endmodule // hsl_modem

// ===== hsl_status_sva.sv
`timescale 1ns/1ps
module hsl_status_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [15:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic irq_o,
   input wire logic [1:0] clear_to_send_n_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_take; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_take: assert property (p_take) else $error("ack late");
   property p_pulse; ack_o |=> !ack_o; endproperty
   a_pulse: assert property (p_pulse) else $error("ack long");
   property p_quiet; !(cyc_i && stb_i) |=> !ack_o; endproperty
   a_quiet: assert property (p_quiet) else $error("ack stray");
   property p_idle; !ack_o |-> dat_o == 32'h0000_0000; endproperty
   a_idle: assert property (p_idle) else $error("data idle");
   property p_rsv; ack_o && !$past(we_i) && $past(adr_i[11:0]) == 12'h008
      |-> dat_o[31:10] == 22'h00_0000; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved set");
   // read word is captured from the second sync stage, three edges late
   property p_cts; ack_o && !$past(we_i) && $past(adr_i) == 16'h7008
      |-> dat_o[6] == !$past(clear_to_send_n_i[0], 3); endproperty
   a_cts: assert property (p_cts) else $error("cts level");
   property p_unmap; ack_o && $past(adr_i) == 16'h7010 |-> dat_o == 0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
   property p_rst; $fell(rst_i) |-> !irq_o && !ack_o; endproperty
   a_rst: assert property (p_rst) else $error("reset irq");
endmodule // hsl_status_sva

// ===== hsl_status_tb_top.sv
`timescale 1ns/1ps
`include "hsl_cfg.svh"
module hsl_status_tb_top;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
   logic [15:0] adr_i;
   logic [3:0] sel_i;
   logic [7:0] ctl;
   logic [31:0] dat_i, dat_o, q, t;
   logic [1:0] flip, cts_n, f1, f4, td, tu, rl, r4, r2, fe;
   logic [1:0][3:0] rb;
   int bad_count, samples_checked;
   integer seed;
   hsl_modem modem_u (.clk_i(clk_i), .flip_i(flip), .clear_to_send_n_o(cts_n));
   hsl_status dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .clear_to_send_n_i(cts_n),
      .tx_fifo_first_empty_i(f1), .tx_fifo_four_empty_i(f4),
      .tx_done_event_i(td), .tx_underrun_event_i(tu),
      .rx_fifo_last_valid_i(rl), .rx_fifo_four_valid_i(r4),
      .rx_fifo_two_last_i(r2), .rx_frame_end_i(fe),
      .rx_leftover_byte_count_i(rb));
   initial begin
      clk_i = 1'h0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic summarize;
      if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [15:0] a,
      input logic [3:0] s, input logic [31:0] d);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, s, d};
      // no wait limit here; the watchdog ends a hung bus
      do @(posedge clk_i); while (ack_o !== 1'h1);
      q = dat_o;
      {cyc_i, stb_i} <= 2'h0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [15:0] a, input logic [31:0] m, e);
      wb(1'h0, a, 4'hf, 32'h0000_0000);
      chk(q & m, e);
   endtask
   function automatic logic [31:0] lv(int c);
      logic [3:0] k;
      k = ctl[c*4 +: 4];
      lv = 32'h0000_0000;
      lv[5] = !k[1] && (k[0] ? f4[c] : f1[c]);
      lv[9] = !k[2] && (k[0] ? r4[c] | r2[c] : rl[c]);
   endfunction
   // about 490 cycles of traffic; a sixteenfold margin flags a hang
   initial begin
      repeat (8000) @(posedge clk_i);
      bad_count++;
      summarize;
   end
   initial begin
      seed = 32'h0000_fb62;
      rst_i = 1'h1;
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, flip} = '0;
      {f1, f4, td, tu, rl, r4, r2, fe, rb} = '0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      rdc(`HSL_STAT_A_OFS, 32'hffff_ffff, 32'h0000_0000);
      rdc(`HSL_STAT_B_OFS, 32'hffff_ffff, 32'h0000_0000);
      rdc(16'h7010, 32'hffff_ffff, 32'h0000_0000);
      repeat (40) begin
         t = $random(seed);
         ctl = t[31:24];
         wb(1'h1, `HSL_CTRL_OFS, 4'hf, {24'h00_0000, ctl});
         // full implies first-word state, so never drive a contradiction
         {f4, f1, r4, rl, r2} <= {t[1:0], t[3:2] | t[1:0], t[5:4],
            t[7:6] | t[5:4], t[9:8] & {ctl[4], ctl[0]}};
         @(posedge clk_i);
         rdc(`HSL_STAT_A_OFS, 32'h0000_0220, lv(0));
         rdc(`HSL_STAT_B_OFS, 32'h0000_0220, lv(1));
      end
      wb(1'h1, `HSL_MASK_A_OFS, 4'hf, 32'h0000_0220);
      chk({31'h0, irq_o}, {31'h0, |(lv(0) & 32'h0000_0220)});
      wb(1'h1, `HSL_MASK_A_OFS, 4'hf, 32'h0000_0000);
      t = $random(seed);
      {td, tu, fe, rb} <= {6'h19, t[7:0]};
      @(posedge clk_i);
      {td, tu, fe} <= 6'h00;
      @(posedge clk_i);
      rdc(`HSL_STAT_A_OFS, 32'h0000_011f, 32'h0000_0010 | t[3:0]);
      rdc(`HSL_STAT_A_OFS, 32'h0000_011f, 32'h0000_0010 | t[3:0]);
      wb(1'h1, `HSL_STAT_A_OFS, 4'hf, 32'h0000_0400);
      rdc(`HSL_STAT_A_OFS, 32'h0000_0410, 32'h0000_0010);
      wb(1'h1, `HSL_STAT_A_OFS, 4'h1, 32'h0000_0010);
      rdc(`HSL_STAT_A_OFS, 32'h0000_0010, 32'h0000_0000);
      rdc(`HSL_STAT_B_OFS, 32'h0000_0110, 32'h0000_0100);
      wb(1'h1, `HSL_STAT_B_OFS, 4'h2, 32'h0000_0100);
      rdc(`HSL_STAT_B_OFS, 32'h0000_0110, 32'h0000_0000);
      for (int i = 0; i < 2; i++) begin
         flip <= 2'h1;
         @(posedge clk_i);
         flip <= 2'h0;
         repeat (6) @(posedge clk_i);
         rdc(`HSL_STAT_A_OFS, 32'h0000_00c0, {1'b1, i == 0, 6'h00});
         wb(1'h1, `HSL_MASK_A_OFS, 4'hf, 32'h0000_0040);
         chk({31'h0, irq_o}, 32'h0000_0000);
         wb(1'h1, `HSL_MASK_A_OFS, 4'hf, 32'h0000_0080);
         chk({31'h0, irq_o}, 32'h0000_0001);
         wb(1'h1, `HSL_STAT_A_OFS, 4'h1, 32'h0000_0080);
         chk({31'h0, irq_o}, 32'h0000_0000);
      end
      summarize;
   end
endmodule // hsl_status_tb_top
bind hsl_status hsl_status_sva chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
   .ack_o(ack_o), .irq_o(irq_o), .clear_to_send_n_i(clear_to_send_n_i));
